//--- src/lgocd_top.sv
// Lock-gated output enables, register file and channel 0 divider output
`timescale 1ns/10ps
`default_nettype none
module lgocd_top
#(
	parameter int N_OUT = lgocd_pkg::N_OUT
)
(
	// Clock and asynchronous reset
	input  wire logic                         mclk,
	input  wire logic                         resetn,
	// Byte-wide register port
	input  wire logic [lgocd_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [lgocd_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                         reg_write,
	input  wire logic                         reg_read,
	output logic      [lgocd_pkg::DATA_W-1:0] reg_rdata,
	// Pins and settings from outside this block
	input  wire logic                         lock_detect_level,
	input  wire logic                         align_pulse,
	input  wire logic [N_OUT-1:0]             other_powerdown,
	// Output enables and channel 0 divided clock
	output logic      [N_OUT-1:0]             clock_output_enable,
	output logic                              divider_clock
);
	// Gate fields fill one byte register and the low half of a second
	if (N_OUT != lgocd_pkg::N_LOW_OUT + lgocd_pkg::N_HIGH_OUT)
		$error("lgocd_top: N_OUT must equal 12");
	// The decoder compares ten-bit offsets and the registers are bytes
	if (lgocd_pkg::ADDR_W != 10)
		$error("lgocd_top: address width must be 10");
	if (lgocd_pkg::DATA_W != 8)
		$error("lgocd_top: data width must be 8");
	// The phase counter holds a four-bit length or offset
	if (lgocd_pkg::CNT_W != 4)
		$error("lgocd_top: counter width must be 4");

	// Register file state and next values
	logic [7:0] gate_low_reg,  gate_low_next;
	logic [7:0] gate_high_reg, gate_high_next;
	logic [7:0] div_phase_reg, div_phase_next;
	logic [7:0] div_ctrl_reg,  div_ctrl_next;
	logic [7:0] rdata_reg,     rdata_next;
	// Two-flop synchronisers for the pins
	logic       align_s1_reg,  align_s2_reg;
	logic       lock_s1_reg,   lock_s2_reg;
	// Retimed divider level and flattened gate bits
	logic       div_out_reg;
	logic [N_OUT-1:0] gate_bits;

	// Settings and status shared with the divider
	lgocd_div_if dif ();

	// Register decode, shared by write and read paths
	// Exact match on all address bits, so no aliases exist
	function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// Register write next values
	// Unused upper bits of the high gate register are stored as zero,
	// so software reads back exactly what the gating logic uses
	always_comb
	begin
		gate_low_next  = gate_low_reg;
		gate_high_next = gate_high_reg;
		div_phase_next = div_phase_reg;
		div_ctrl_next  = div_ctrl_reg;
		if (reg_write)
		begin
			if (hit(reg_addr, lgocd_pkg::OFS_GATE_LOW))
				gate_low_next = reg_wdata;
			if (hit(reg_addr, lgocd_pkg::OFS_GATE_HIGH))
				gate_high_next = {4'h0, reg_wdata[lgocd_pkg::N_HIGH_OUT-1:0]};
			if (hit(reg_addr, lgocd_pkg::OFS_DIV_PHASE))
				div_phase_next = reg_wdata;
			if (hit(reg_addr, lgocd_pkg::OFS_DIV_CTRL))
				div_ctrl_next = reg_wdata;
		end
	end

	// Read data, registered; unmapped addresses read zero.
	// The status byte at the top offset is read-only: bit 0 divider
	// level, bit 1 synchronised lock level, bit 2 divider parked in hold.
	// A read in the same cycle as a write sees the older value.
	always_comb
	begin
		rdata_next = rdata_reg;
		if (reg_read)
		begin
			rdata_next = 8'h00;
			if (hit(reg_addr, lgocd_pkg::OFS_GATE_LOW))
				rdata_next = gate_low_reg;
			if (hit(reg_addr, lgocd_pkg::OFS_GATE_HIGH))
				rdata_next = gate_high_reg;
			if (hit(reg_addr, lgocd_pkg::OFS_DIV_PHASE))
				rdata_next = div_phase_reg;
			if (hit(reg_addr, lgocd_pkg::OFS_DIV_CTRL))
				rdata_next = div_ctrl_reg;
			if (hit(reg_addr, lgocd_pkg::OFS_STATUS))
			begin
				rdata_next[lgocd_pkg::ST_DIV_BIT]  = dif.div_level;
				rdata_next[lgocd_pkg::ST_LOCK_BIT] = lock_s2_reg;
				rdata_next[lgocd_pkg::ST_HOLD_BIT] = dif.holding;
			end
		end
	end

	// Register file; gate bits clear at reset
	// Divider settings reset to eight-cycle low and high phases
	// gating off by default
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			gate_low_reg  <= lgocd_pkg::RST_GATE;
			gate_high_reg <= lgocd_pkg::RST_GATE;
			div_phase_reg <= lgocd_pkg::RST_DIV_PHASE;
			div_ctrl_reg  <= lgocd_pkg::RST_DIV_CTRL;
			rdata_reg     <= 8'h00;
		end
		else
		begin
			gate_low_reg  <= gate_low_next;
			gate_high_reg <= gate_high_next;
			div_phase_reg <= div_phase_next;
			div_ctrl_reg  <= div_ctrl_next;
			rdata_reg     <= rdata_next;
		end
	end
	assign reg_rdata = rdata_reg;

	// Pin synchronisers; lock copy only feeds the status read
	// The alignment pin passes both flops before the divider sees it,
	// otherwise a level changing near the edge could split the state
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			align_s1_reg <= 1'b0;
			align_s2_reg <= 1'b0;
			lock_s1_reg  <= 1'b0;
			lock_s2_reg  <= 1'b0;
		end
		else
		begin
			align_s1_reg <= align_pulse;
			align_s2_reg <= align_s1_reg;
			lock_s1_reg  <= lock_detect_level;
			lock_s2_reg  <= lock_s1_reg;
		end
	end

	// Divider settings fanned out from the registers
	// Length changes take effect at the divider's next phase reload, so a
	// length written mid-phase does not cut the running phase short
	assign dif.low_len      = div_phase_reg[lgocd_pkg::LOW_MSB:lgocd_pkg::LOW_LSB];
	assign dif.high_len     = div_phase_reg[lgocd_pkg::HIGH_MSB:lgocd_pkg::HIGH_LSB];
	assign dif.bypass       = div_ctrl_reg[lgocd_pkg::BYPASS_BIT];
	assign dif.ignore_align = div_ctrl_reg[lgocd_pkg::IGNORE_BIT];
	assign dif.force_level  = div_ctrl_reg[lgocd_pkg::FORCE_BIT];
	assign dif.start_level  = div_ctrl_reg[lgocd_pkg::START_BIT];
	assign dif.phase_offset = div_ctrl_reg[lgocd_pkg::OFFSET_MSB:lgocd_pkg::OFFSET_LSB];
	assign dif.align_level  = align_s2_reg;

	lgocd_divider u_div
	(
		.mclk   (mclk),
		.resetn (resetn),
		.dif    (dif.div)
	);

	// Retime divider level so the output comes from a flip-flop
	// It also hides the force-level switch from the loads' timing
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			div_out_reg <= 1'b0;
		else
			div_out_reg <= dif.div_level;
	end

	// Bypass routes the input clock straight out; a mux on a clock can
	// glitch when the bit flips, so change it only while loads are off
	// bypass routing
	assign divider_clock = dif.bypass ? mclk : div_out_reg;

	assign gate_bits = {gate_high_reg[lgocd_pkg::N_HIGH_OUT-1:0], gate_low_reg};

	// Lock gating is combinational on purpose: power-down must follow
	// the lock level without waiting for a clock edge.
	// A glitch on the raw pin reaches the enables directly, so the
	// lock detector must drive a clean level
	for (genvar i = 0; i < N_OUT; i++)
	begin : g_gate
		assign clock_output_enable[i] = ~other_powerdown[i] & (~gate_bits[i] | lock_detect_level);
	end
endmodule : lgocd_top
`default_nettype wire

//--- src/lgocd_pkg.sv
// Constants for the lock-gated output and channel 0 divider block
package lgocd_pkg;
	localparam int          ADDR_W        = 10;
	localparam int          DATA_W        = 8;
	localparam int          N_OUT         = 12;
	localparam int          N_LOW_OUT     = 8;
	localparam int          N_HIGH_OUT    = 4;
	localparam int          CNT_W         = 4;

	localparam logic [9:0]  OFS_GATE_LOW  = 10'h0FC;
	localparam logic [9:0]  OFS_GATE_HIGH = 10'h0FD;
	localparam logic [9:0]  OFS_DIV_PHASE = 10'h190;
	localparam logic [9:0]  OFS_DIV_CTRL  = 10'h191;
	localparam logic [9:0]  OFS_STATUS    = 10'h1FF;

	localparam logic [7:0]  RST_GATE      = 8'h00;
	localparam logic [7:0]  RST_DIV_PHASE = 8'h77;
	localparam logic [7:0]  RST_DIV_CTRL  = 8'h00;

	localparam int          LOW_MSB       = 7;
	localparam int          LOW_LSB       = 4;
	localparam int          HIGH_MSB      = 3;
	localparam int          HIGH_LSB      = 0;
	localparam int          BYPASS_BIT    = 7;
	localparam int          IGNORE_BIT    = 6;
	localparam int          FORCE_BIT     = 5;
	localparam int          START_BIT     = 4;
	localparam int          OFFSET_MSB    = 3;
	localparam int          OFFSET_LSB    = 0;
	localparam int          ST_DIV_BIT    = 0;
	localparam int          ST_LOCK_BIT   = 1;
	localparam int          ST_HOLD_BIT   = 2;

	localparam logic [3:0]  CNT_ZERO      = 4'h0;
	localparam logic [3:0]  CNT_ONE       = 4'h1;

	typedef enum logic [1:0]
	{
		LGOCD_HOLD   = 2'b00,
		LGOCD_OFFSET = 2'b01,
		LGOCD_LOW    = 2'b10,
		LGOCD_HIGH   = 2'b11
	} lgocd_div_state_t;
endpackage : lgocd_pkg

//--- src/lgocd_div_if.sv
// Carrier between the register file and the channel 0 divider
`timescale 1ns/10ps
`default_nettype none
interface lgocd_div_if;
	logic [3:0] low_len;
	logic [3:0] high_len;
	logic       bypass;
	logic       ignore_align;
	logic       force_level;
	logic       start_level;
	logic [3:0] phase_offset;
	logic       align_level;
	logic       div_level;
	logic       holding;

	modport ctrl
	(
		output low_len, high_len, bypass, ignore_align, force_level, start_level,
		output phase_offset, align_level,
		input  div_level, holding
	);
	modport div
	(
		input  low_len, high_len, bypass, ignore_align, force_level, start_level,
		input  phase_offset, align_level,
		output div_level, holding
	);
endinterface : lgocd_div_if
`default_nettype wire

//--- src/lgocd_divider.sv
// Channel 0 divider: programmable low/high phases, alignment hold and offset
`timescale 1ns/10ps
`default_nettype none
module lgocd_divider
(
	input  wire logic  mclk,
	input  wire logic  resetn,
	lgocd_div_if.div   dif
);
	lgocd_pkg::lgocd_div_state_t state_reg, state_next;
	logic [3:0]                  cnt_reg,   cnt_next;
	logic                        level_reg, level_next;
	logic                        obey;

	// Alignment pulse only counts when the ignore bit is clear
	// obey alignment pulse
	assign obey = dif.align_level & ~dif.ignore_align;

	// Next-state logic of the phase sequencer
	always_comb
	begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		level_next = level_reg;
		if (obey)
		begin
			// Held at start level while aligned
			// start level choice
			state_next = lgocd_pkg::LGOCD_HOLD;
			cnt_next   = lgocd_pkg::CNT_ZERO;
			level_next = dif.start_level;
		end
		else
		begin
			case (state_reg)
				lgocd_pkg::LGOCD_HOLD:
				begin
					state_next = lgocd_pkg::LGOCD_OFFSET;
					cnt_next   = dif.phase_offset;
					level_next = dif.start_level;
				end
				lgocd_pkg::LGOCD_OFFSET:
				begin
					if (cnt_reg == lgocd_pkg::CNT_ZERO)
					begin
						state_next = dif.start_level ? lgocd_pkg::LGOCD_HIGH : lgocd_pkg::LGOCD_LOW;
						cnt_next   = dif.start_level ? dif.high_len : dif.low_len;
						level_next = dif.start_level;
					end
					else
						cnt_next = cnt_reg - lgocd_pkg::CNT_ONE;
				end
				lgocd_pkg::LGOCD_LOW:
				begin
					if (cnt_reg == lgocd_pkg::CNT_ZERO)
					begin
						state_next = lgocd_pkg::LGOCD_HIGH;
						cnt_next   = dif.high_len;
						level_next = 1'b1;
					end
					else
						cnt_next = cnt_reg - lgocd_pkg::CNT_ONE;
				end
				lgocd_pkg::LGOCD_HIGH:
				begin
					if (cnt_reg == lgocd_pkg::CNT_ZERO)
					begin
						state_next = lgocd_pkg::LGOCD_LOW;
						cnt_next   = dif.low_len;
						level_next = 1'b0;
					end
					else
						cnt_next = cnt_reg - lgocd_pkg::CNT_ONE;
				end
				default:
				begin
					state_next = lgocd_pkg::LGOCD_HOLD;
					cnt_next   = lgocd_pkg::CNT_ZERO;
					level_next = 1'b0;
				end
			endcase
		end
		// Bypass powers the divider down, so it parks in hold
		// divider powered down
		if (dif.bypass)
		begin
			state_next = lgocd_pkg::LGOCD_HOLD;
			cnt_next   = lgocd_pkg::CNT_ZERO;
			level_next = dif.start_level;
		end
	end

	// Sequencer registers
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= lgocd_pkg::LGOCD_HOLD;
			cnt_reg   <= lgocd_pkg::CNT_ZERO;
			level_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			level_reg <= level_next;
		end
	end

	// Force level overrides only while the ignored pulse is present
	// force level
	assign dif.div_level = (dif.ignore_align & dif.align_level) ? dif.force_level : level_reg;
	assign dif.holding   = (state_reg == lgocd_pkg::LGOCD_HOLD);
endmodule : lgocd_divider
`default_nettype wire

//--- dv/lgocd_top_asserts.sv
// Port-level checker for the lock-gated output block
`timescale 1ns/10ps
`default_nettype none
module lgocd_top_asserts
#(
	parameter int N_OUT = 12
)
(
	input wire logic             mclk,
	input wire logic             resetn,
	input wire logic [9:0]       reg_addr,
	input wire logic [7:0]       reg_wdata,
	input wire logic             reg_write,
	input wire logic             reg_read,
	input wire logic [7:0]       reg_rdata,
	input wire logic             lock_detect_level,
	input wire logic             align_pulse,
	input wire logic [N_OUT-1:0] other_powerdown,
	input wire logic [N_OUT-1:0] clock_output_enable,
	input wire logic             divider_clock
);
	logic [N_OUT-1:0] g_reg;
	logic [7:0]       ph_reg;
	logic [7:0]       ct_reg;
	logic [5:0]       quiet_reg;
	logic [5:0]       run_reg;
	logic             lst_reg;

	// Shadows; quiet waits out phase reloads after writes or alignment
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
		begin
			g_reg     <= '0;
			ph_reg    <= 8'h77;
			ct_reg    <= 8'h00;
			quiet_reg <= 6'h00;
			run_reg   <= 6'h00;
			lst_reg   <= 1'b0;
		end
		else
		begin
			if (reg_write && reg_addr == 10'h0FC)
				g_reg[7:0] <= reg_wdata;
			if (reg_write && reg_addr == 10'h0FD)
				g_reg[N_OUT-1:8] <= reg_wdata[N_OUT-9:0];
			if (reg_write && reg_addr == 10'h190)
				ph_reg <= reg_wdata;
			if (reg_write && reg_addr == 10'h191)
				ct_reg <= reg_wdata;
			if (align_pulse || (reg_write && reg_addr[9:1] == 9'h0C8))
				quiet_reg <= 6'h00;
			else if (quiet_reg != 6'h3F)
				quiet_reg <= quiet_reg + 6'h01;
			if (divider_clock != lst_reg)
				run_reg <= 6'h01;
			else if (run_reg != 6'h3F)
				run_reg <= run_reg + 6'h01;
			lst_reg <= divider_clock;
		end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	property p_gate_on;
		lock_detect_level |-> (g_reg & ~other_powerdown & ~clock_output_enable) == '0;
	endproperty
	a_gate_on: assert property (p_gate_on) else $error("gated output stays off");
	property p_gate_off;
		!lock_detect_level |-> (g_reg & clock_output_enable) == '0;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("gated output on without lock");
	property p_gate_clear;
		(~g_reg & (clock_output_enable ^ ~other_powerdown)) == '0;
	endproperty
	a_gate_clear: assert property (p_gate_clear) else $error("ungated output disturbed");
	property p_rd_high;
		reg_read && reg_addr == 10'h0FD |=> reg_rdata == {4'h0, $past(g_reg[N_OUT-1:8])};
	endproperty
	a_rd_high: assert property (p_rd_high) else $error("high gate readback wrong");
	property p_low_len;
		$rose(divider_clock) && quiet_reg == 6'h3F && !ct_reg[7] |-> run_reg == {2'b00, ph_reg[7:4]} + 6'h01;
	endproperty
	a_low_len: assert property (p_low_len) else $error("low phase length wrong");
	property p_high_len;
		$fell(divider_clock) && quiet_reg == 6'h3F && !ct_reg[7] |-> run_reg == {2'b00, ph_reg[3:0]} + 6'h01;
	endproperty
	a_high_len: assert property (p_high_len) else $error("high phase length wrong");
	property p_align_hold;
		(align_pulse && !ct_reg[6] && !ct_reg[7])[*7] |-> divider_clock == ct_reg[4];
	endproperty
	a_align_hold: assert property (p_align_hold) else $error("alignment hold level wrong");
	property p_force;
		(align_pulse && ct_reg[6] && !ct_reg[7])[*7] |-> divider_clock == ct_reg[5];
	endproperty
	a_force: assert property (p_force) else $error("forced level wrong");

	c_rise: cover property ($rose(divider_clock) && quiet_reg == 6'h3F);
	c_rd_high: cover property (reg_read && reg_addr == 10'h0FD);
	c_force: cover property (align_pulse && ct_reg[6]);
endmodule : lgocd_top_asserts

bind lgocd_top lgocd_top_asserts #(.N_OUT(N_OUT)) u_asserts
(
	.mclk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
	.lock_detect_level, .align_pulse, .other_powerdown, .clock_output_enable, .divider_clock
);
`default_nettype wire

//--- dv/lgocd_clock_load.sv
// Clock load model measuring the divided clock period
`timescale 1ns/10ps
`default_nettype none
module lgocd_clock_load
(
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       enable,
	input  wire logic       clk_in,
	output logic      [6:0] period
);
	logic [6:0] cnt_reg;
	logic       lst_reg;

	// rise to rise
	// A disabled output looks dead to the load, so no rise is seen
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
		begin
			cnt_reg <= 7'h00;
			lst_reg <= 1'b0;
			period  <= 7'h00;
		end
		else
		begin
			lst_reg <= clk_in & enable;
			cnt_reg <= (clk_in && enable && !lst_reg) ? 7'h01 : cnt_reg + 7'h01;
			if (clk_in && enable && !lst_reg)
				period <= cnt_reg;
		end
endmodule : lgocd_clock_load
`default_nettype wire

//--- dv/tb_lock_gated_output_channel_divider.sv
// Self-checking bench for the lock-gated output block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_lock_gated_output_channel_divider;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic [9:0]  reg_addr = 10'h000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [7:0]  reg_rdata;
	logic        lock_detect_level = 1'b0;
	logic        align_pulse = 1'b0;
	logic [11:0] other_powerdown = 12'h000;
	logic [11:0] clock_output_enable;
	logic        divider_clock;
	logic [6:0]  period;
	logic [11:0] g;
	logic [7:0]  ph;
	logic [7:0]  d;
	int          bad_count = 0;
	int          comparisons = 0;
	int          cyc = 0;
	logic [9:0]  rst_a [5] = '{10'h0FC, 10'h0FD, 10'h190, 10'h191, 10'h055};
	logic [7:0]  rst_d [5] = '{8'h00, 8'h00, 8'h77, 8'h00, 8'h00};
	logic [7:0]  al_c [4] = '{8'h00, 8'h10, 8'h70, 8'h50};

	lgocd_top dut (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.lock_detect_level, .align_pulse, .other_powerdown, .clock_output_enable, .divider_clock);
	lgocd_clock_load u_load (.mclk, .resetn, .enable(clock_output_enable[0]), .clk_in(divider_clock), .period);

	always #5 mclk = ~mclk;

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	// Runs take about 1050 cycles; a hang is cut well after
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			finish_test();
		end
	end

	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = v;
		reg_write = 1'b1;
		@(negedge mclk);
		reg_write = 1'b0;
	endtask : wr

	task automatic rd(input logic [9:0] a, output logic [7:0] v);
		@(negedge mclk);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge mclk);
		reg_read = 1'b0;
		v = reg_rdata;
	endtask : rd

	function automatic logic [11:0] exp_en(logic [11:0] gb, logic [11:0] pd, logic lk);
		return ~pd & (~gb | {12{lk}});
	endfunction : exp_en

	initial
	begin
		void'($urandom(32'hB527));
		repeat (16) @(negedge mclk);
		resetn = 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			rd(rst_a[i], d);
			`CHK("reset value", rst_d[i], d)
		end
		$display("test reset done");
		// Upper bits of the high gate register are written as ones on purpose
		for (int i = 0; i < 24; i++)
		begin
			g = (i < 2) ? 12'hFFF : 12'($urandom);
			wr(10'h0FC, g[7:0]);
			wr(10'h0FD, {4'hF, g[11:8]});
			other_powerdown = (i < 2) ? 12'h000 : 12'($urandom);
			// clean lock level from the detector
			lock_detect_level = (i < 2) ? i[0] : 1'($urandom);
			#1;
			`CHK("enable", exp_en(g, other_powerdown, lock_detect_level), clock_output_enable)
			rd(10'h0FD, d);
			`CHK("gate high", {4'h0, g[11:8]}, d)
		end
		$display("test gating done");
		wr(10'h0FC, 8'h00);
		other_powerdown = 12'h000;
		for (int i = 0; i < 6; i++)
		begin
			ph = (i == 0) ? 8'h00 : (i == 1) ? 8'hF0 : 8'($urandom);
			wr(10'h190, ph);
			repeat (100) @(negedge mclk);
			`CHK("period", 7'(ph[7:4] + ph[3:0] + 2), period)
		end
		$display("test divider done");
		wr(10'h191, 8'h80);
		@(posedge mclk);
		#1;
		`CHK("bypass high", 1'b1, divider_clock)
		@(negedge mclk);
		#1;
		`CHK("bypass low", 1'b0, divider_clock)
		$display("test bypass done");
		for (int i = 0; i < 4; i++)
		begin
			wr(10'h191, al_c[i]);
			align_pulse = 1'b1;
			repeat (10) @(negedge mclk);
			`CHK("align level", (i == 3) ? 1'b0 : (i > 0), divider_clock)
			rd(10'h1FF, d);
			`CHK("hold status", {i < 2, lock_detect_level}, d[2:1])
			align_pulse = 1'b0;
			repeat (40) @(negedge mclk);
		end
		$display("test align done");
		// Obeyed alignment with the largest offset; first rise trails offset and low phase
		wr(10'h191, 8'h0F);
		align_pulse = 1'b1;
		repeat (10) @(negedge mclk);
		align_pulse = 1'b0;
		repeat (20 + ph[7:4]) @(negedge mclk);
		`CHK("offset low", 1'b0, divider_clock)
		@(negedge mclk);
		`CHK("offset rise", 1'b1, divider_clock)
		$display("test offset done");
		finish_test();
	end
endmodule : tb_lock_gated_output_channel_divider
`default_nettype wire
